// ==== inc/node_status_pkg.sv ====
package node_status_pkg;

	// ---------------------------------------------------------------
	// Geometry
	// ---------------------------------------------------------------
	localparam int NODE_COUNT = 64;
	localparam int NODE_W = 6;
	localparam int CODE_W = 16;
	localparam int MAP_W = 16;
	localparam int ADDR_W = 12;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [11:0] OFS_STACK_VERSION = 12'h000;
	localparam logic [11:0] OFS_BAUD_RATE = 12'h004;
	localparam logic [11:0] OFS_MASTER_STATE = 12'h008;
	localparam logic [11:0] OFS_FAULT_MAP_1_16 = 12'h00c;
	localparam logic [11:0] OFS_FAULT_MAP_17_32 = 12'h010;
	localparam logic [11:0] OFS_FAULT_MAP_33_48 = 12'h014;
	localparam logic [11:0] OFS_FAULT_MAP_49_64 = 12'h018;
	localparam logic [11:0] OFS_NODE_CODES = 12'h100;
	localparam logic [11:0] OFS_NODE_CODES_LAST = 12'h1fc;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] RST_CODE = 16'h0000;
	localparam logic [15:0] RST_BAUD = 16'h0000;
	localparam logic [15:0] RST_MASTER = 16'h0000;
	localparam logic [63:0] RST_FAULT_MAP = 64'h0;

	// ---------------------------------------------------------------
	// Node error codes
	// ---------------------------------------------------------------
	localparam logic [15:0] NODE_OK = 16'h0000;
	localparam logic [15:0] NODE_EMCY = 16'h00e0;
	localparam logic [15:0] NODE_PDO_LEN = 16'h00e1;
	localparam logic [15:0] NODE_PDO_MISSING = 16'h00e2;
	localparam logic [15:0] NODE_SDO_FAIL = 16'h00e3;
	localparam logic [15:0] NODE_PDO_CFG_FAIL = 16'h00e4;
	localparam logic [15:0] NODE_KEY_FAIL = 16'h00e5;
	localparam logic [15:0] NODE_ABSENT = 16'h00e6;
	localparam logic [15:0] NODE_GUARD_TIMEOUT = 16'h00e7;
	localparam logic [15:0] NODE_ID_DUP = 16'h00e8;

	// ---------------------------------------------------------------
	// Master state codes
	// ---------------------------------------------------------------
	localparam logic [15:0] MST_OK = 16'h0000;
	localparam logic [15:0] MST_NO_SLAVE = 16'h00f1;
	localparam logic [15:0] MST_DOWNLOADING = 16'h00f2;
	localparam logic [15:0] MST_CFG_ERROR = 16'h00f3;
	localparam logic [15:0] MST_BUS_OFF = 16'h00f4;
	localparam logic [15:0] MST_SETTING_ERROR = 16'h00f5;
	localparam logic [15:0] MST_MEM_ERROR = 16'h00f8;
	localparam logic [15:0] MST_TX_FULL = 16'h00fb;
	localparam logic [15:0] MST_RX_FULL = 16'h00fc;

	// ---------------------------------------------------------------
	// Node event kinds reported by the fieldbus engine
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		KIND_HEALTHY,
		KIND_EMCY,
		KIND_PDO_LEN,
		KIND_PDO_MISSING,
		KIND_SDO_FAIL,
		KIND_PDO_CFG_FAIL,
		KIND_KEY_FAIL,
		KIND_ABSENT,
		KIND_GUARD_TIMEOUT,
		KIND_ID_DUP
	} ev_kind_e;

endpackage

// ==== inc/code_mem_if.sv ====
`timescale 1ns/1ps
interface code_mem_if #(
	parameter int ADDR_W = 6,
	parameter int DATA_W = 16
);
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;

	modport user (
		output wr_en,
		output wr_addr,
		output wr_data,
		output rd_addr,
		input rd_data
	);

	modport mem (
		input wr_en,
		input wr_addr,
		input wr_data,
		input rd_addr,
		output rd_data
	);
endinterface

// ==== rtl/node_code_mem.sv ====
`timescale 1ns/1ps
module node_code_mem #(
	parameter int DEPTH = 64,
	parameter int DATA_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	code_mem_if.mem bus
);
	typedef struct packed {
		logic [DEPTH-1:0][DATA_W-1:0] word;
		logic [DATA_W-1:0] rd_data;
	} mem_s;

	mem_s mem_reg;
	mem_s mem_next;

	// Read data registered; a same-cycle write shows on the next read
	always_comb begin
		mem_next = mem_reg;
		mem_next.rd_data = mem_reg.word[bus.rd_addr];
		if (bus.wr_en) begin
			mem_next.word[bus.wr_addr] = bus.wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_reg <= '0;
		end else begin
			mem_reg <= mem_next;
		end
	end

	assign bus.rd_data = mem_reg.rd_data;
endmodule

// ==== rtl/fieldbus_node_status_monitor.sv ====
`timescale 1ns/1ps
// Operation
// - Four 16-bit fault maps, b0 lowest node
// - Bit clear when healthy, set when abnormal
// - One code word per node, node 1 first
// - Code 0 when error free or unconfigured
// - Code E0 on emergency from slave
// - Code E1 on PDO length mismatch
// - Code E2 when expected PDO missing
// - Code E3 when automatic SDO download fails
// - Code E4 when PDO configuration fails
// - Code E5 when key parameter check fails
// - Code E6 when configured slave absent
// - Code E7 on error-control supervision timeout
// - Code E8 on duplicate node identifier
// - State 0 when normal or master inactive
// - State F1 when node list empty
// - State F2 while configuration downloads
// - State F3 on configuration receive error
// - State F4 on CAN bus-off
// - State F5 on own setting error
// - State F8 on internal memory error
// - State FB transmit full, FC receive full
// - Baud rate readout in thousands per second
module fieldbus_node_status_monitor #(
	parameter logic [15:0] STACK_VERSION = 16'h0101, // Arbitrary value
	parameter int NODES = 64
) (
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Node list and node events from the fieldbus engine
	input wire logic [NODES-1:0] node_configured,
	input wire logic node_event_valid,
	input wire logic [5:0] node_event_index,
	input wire logic [3:0] node_event_kind,
	// Master condition levels
	input wire logic master_enable,
	input wire logic cfg_downloading,
	input wire logic cfg_receive_error,
	input wire logic can_bus_off,
	input wire logic own_setting_error,
	input wire logic [6:0] own_node_id,
	input wire logic internal_mem_error,
	input wire logic tx_buffer_full,
	input wire logic rx_buffer_full,
	input wire logic [15:0] bus_rate_kbps
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [15:0] master_state;
		logic [15:0] baud;
		logic [NODES-1:0] fault;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_s;

	state_s state_reg;
	state_s state_next;

	code_mem_if #(.ADDR_W(6), .DATA_W(16)) mem_bus ();

	node_code_mem #(
		.DEPTH(NODES),
		.DATA_W(16)
	) u_codes (
		.clk(clk),
		.rst_n(rst_n),
		.bus(mem_bus)
	);

	// ---------------------------------------------------------------
	// Decode helpers
	// ---------------------------------------------------------------
	function automatic logic is_code_addr(input logic [11:0] a);
		is_code_addr = (a >= node_status_pkg::OFS_NODE_CODES) &&
			(a <= node_status_pkg::OFS_NODE_CODES_LAST) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [15:0] kind_to_code(input logic [3:0] k);
		case (node_status_pkg::ev_kind_e'(k))
			node_status_pkg::KIND_HEALTHY: kind_to_code = node_status_pkg::NODE_OK;
			node_status_pkg::KIND_EMCY: kind_to_code = node_status_pkg::NODE_EMCY;
			node_status_pkg::KIND_PDO_LEN: kind_to_code = node_status_pkg::NODE_PDO_LEN;
			node_status_pkg::KIND_PDO_MISSING: begin
				kind_to_code = node_status_pkg::NODE_PDO_MISSING;
			end
			node_status_pkg::KIND_SDO_FAIL: kind_to_code = node_status_pkg::NODE_SDO_FAIL;
			node_status_pkg::KIND_PDO_CFG_FAIL: begin
				kind_to_code = node_status_pkg::NODE_PDO_CFG_FAIL;
			end
			node_status_pkg::KIND_KEY_FAIL: kind_to_code = node_status_pkg::NODE_KEY_FAIL;
			node_status_pkg::KIND_ABSENT: kind_to_code = node_status_pkg::NODE_ABSENT;
			node_status_pkg::KIND_GUARD_TIMEOUT: begin
				kind_to_code = node_status_pkg::NODE_GUARD_TIMEOUT;
			end
			node_status_pkg::KIND_ID_DUP: kind_to_code = node_status_pkg::NODE_ID_DUP;
			default: kind_to_code = node_status_pkg::NODE_OK;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Node events
	// ---------------------------------------------------------------
	logic ev_kind_known;
	logic ev_accept;
	logic [15:0] ev_code;

	always_comb begin
		ev_kind_known = (node_event_kind <= 4'(node_status_pkg::KIND_ID_DUP));
		// Events for nodes outside the list are dropped so their stored code is left unchanged
		ev_accept = node_event_valid && ev_kind_known &&
			node_configured[node_event_index];
		ev_code = kind_to_code(node_event_kind);
	end

	assign mem_bus.wr_en = ev_accept;
	assign mem_bus.wr_addr = node_event_index;
	assign mem_bus.wr_data = ev_code;
	// Word index of the node codes area, node 1 at the lowest word
	assign mem_bus.rd_addr = paddr[7:2];

	// ---------------------------------------------------------------
	// Master state priority
	// ---------------------------------------------------------------
	logic [15:0] master_code;
	logic setting_bad;

	always_comb begin
		// Node id 0 is the only value outside 1..127 for a 7-bit field
		setting_bad = own_setting_error || (own_node_id == 7'h00);
		if (!master_enable) begin
			master_code = node_status_pkg::MST_OK;
		end else if (internal_mem_error) begin
			master_code = node_status_pkg::MST_MEM_ERROR;
		end else if (can_bus_off) begin
			// Stays until reboot; the engine holds the level
			master_code = node_status_pkg::MST_BUS_OFF;
		end else if (tx_buffer_full) begin
			master_code = node_status_pkg::MST_TX_FULL;
		end else if (rx_buffer_full) begin
			master_code = node_status_pkg::MST_RX_FULL;
		end else if (setting_bad) begin
			master_code = node_status_pkg::MST_SETTING_ERROR;
		end else if (cfg_receive_error) begin
			master_code = node_status_pkg::MST_CFG_ERROR;
		end else if (cfg_downloading) begin
			master_code = node_status_pkg::MST_DOWNLOADING;
		end else if (node_configured == '0) begin
			master_code = node_status_pkg::MST_NO_SLAVE;
		end else begin
			master_code = node_status_pkg::MST_OK;
		end
	end

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	logic [15:0] rd_value;
	logic rd_hit;
	logic [NODES-1:0] fault_shown;

	always_comb begin
		fault_shown = state_reg.fault & node_configured;
		rd_value = 16'h0000;
		rd_hit = 1'b1;
		if (is_code_addr(paddr)) begin
			// Unconfigured nodes read 0 whatever the stored code
			rd_value = node_configured[paddr[7:2]] ? mem_bus.rd_data :
				node_status_pkg::NODE_OK;
		end else begin
			case (paddr)
				node_status_pkg::OFS_STACK_VERSION: rd_value = STACK_VERSION;
				node_status_pkg::OFS_BAUD_RATE: rd_value = state_reg.baud;
				node_status_pkg::OFS_MASTER_STATE: rd_value = state_reg.master_state;
				node_status_pkg::OFS_FAULT_MAP_1_16: rd_value = fault_shown[15:0];
				node_status_pkg::OFS_FAULT_MAP_17_32: rd_value = fault_shown[31:16];
				node_status_pkg::OFS_FAULT_MAP_33_48: rd_value = fault_shown[47:32];
				node_status_pkg::OFS_FAULT_MAP_49_64: rd_value = fault_shown[63:48];
				default: rd_hit = 1'b0;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	logic access_first;

	always_comb begin
		state_next = state_reg;
		access_first = psel && penable && !state_reg.pready;
		state_next.master_state = master_code;
		state_next.baud = bus_rate_kbps;
		// Dropped nodes lose their fault bit
		state_next.fault = state_reg.fault & node_configured;
		if (ev_accept) begin
			state_next.fault[node_event_index] =
				(ev_code != node_status_pkg::NODE_OK);
		end
		// One wait state: memory read data lands in the first access cycle
		state_next.pready = access_first;
		state_next.pslverr = 1'b0;
		if (access_first) begin
			// All registers are read-only; writes are refused
			state_next.pslverr = pwrite || !rd_hit;
			state_next.prdata = (pwrite || !rd_hit) ? 32'h0 : {16'h0000, rd_value};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.master_state <= node_status_pkg::RST_MASTER;
			state_reg.baud <= node_status_pkg::RST_BAUD;
			state_reg.fault <= NODES'(node_status_pkg::RST_FAULT_MAP);
			state_reg.prdata <= 32'h0;
			state_reg.pready <= 1'b0;
			state_reg.pslverr <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;

endmodule

// ==== sim/node_status_props.sv ====
`timescale 1ns/1ps
module node_status_props #(
	parameter logic [15:0] STACK_VERSION = 16'h0101,
	parameter int NODES = 64
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NODES-1:0] node_configured,
	input wire logic master_enable,
	input wire logic can_bus_off,
	input wire logic internal_mem_error,
	input wire logic tx_buffer_full,
	input wire logic [15:0] bus_rate_kbps
);
	logic [2:0] q;
	logic [19:0] mv;
	logic rd;
	assign mv = {master_enable, internal_mem_error, can_bus_off, tx_buffer_full, bus_rate_kbps};
	assign rd = pready && !pwrite;
	// ---------------------------------------------------------------
	// Quiet inputs: registered copies have settled
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= 3'h0;
		end else begin
			q <= {q[1:0], $stable(mv) && $stable(node_configured)};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_ms(c, v);
		rd && paddr == 12'h008 && &q && $stable(mv) && c |-> prdata == {16'h0000, v};
	endproperty
	AST_MS_OFF: assert property (p_ms(!master_enable, 16'h0000))
		else $error("state not zero when disabled");
	AST_MS_MEM: assert property (p_ms(master_enable && internal_mem_error, 16'h00f8))
		else $error("state not f8");
	AST_MS_BUSOFF: assert property (p_ms(master_enable && !internal_mem_error && can_bus_off,
		16'h00f4))
		else $error("state not f4");
	AST_MS_TX: assert property (p_ms(master_enable && !internal_mem_error && !can_bus_off
		&& tx_buffer_full, 16'h00fb))
		else $error("state not fb");
	AST_BAUD: assert property (rd && paddr == 12'h004 && &q && $stable(mv)
		|-> prdata == {16'h0000, bus_rate_kbps})
		else $error("baud readout wrong");
	AST_UNCFG: assert property (rd && paddr[11:8] == 4'h1 && paddr[1:0] == 2'h0 && &q
		&& !node_configured[paddr[7:2]] |-> prdata == 32'h0)
		else $error("unconfigured node code not zero");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("ready not after one wait state");
	AST_WR_REFUSE: assert property (pready && pwrite |-> pslverr && prdata == 32'h0)
		else $error("write not refused");
	AST_VERSION: assert property (rd && paddr == 12'h000 |-> prdata == {16'h0000, STACK_VERSION})
		else $error("version readout wrong");
	cover property (rd && paddr == 12'h008 && prdata == 32'h0000_00f1);
	cover property (pready && pslverr && !pwrite);
	cover property (rd && paddr[8] && prdata != 32'h0);
endmodule
bind fieldbus_node_status_monitor node_status_props #(.STACK_VERSION(STACK_VERSION),
	.NODES(NODES)) u_props (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .node_configured(node_configured),
	.master_enable(master_enable), .can_bus_off(can_bus_off),
	.internal_mem_error(internal_mem_error), .tx_buffer_full(tx_buffer_full),
	.bus_rate_kbps(bus_rate_kbps));

// ==== sim/node_event_model.sv ====
`timescale 1ns/1ps
module node_event_model (
	input wire logic clk,
	output logic valid,
	output logic [5:0] index,
	output logic [3:0] kind
);
	initial begin
		valid = 1'b0;
		index = 6'h2a;
		kind = 4'h5;
	end
	// After a report, idle lines carry the inverse, never a stale event
	task automatic report(input logic [5:0] i, input logic [3:0] k, input int g);
		repeat (g) @(posedge clk);
		@(posedge clk);
		valid <= 1'b1;
		index <= i;
		kind <= k;
		@(posedge clk);
		valid <= 1'b0;
		index <= ~i;
		kind <= ~k;
	endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	localparam logic [15:0] SV = 16'h2a17; // Arbitrary value
	localparam logic [11:0] BAD [4] = '{12'h008, 12'h020, 12'h0fe, 12'h200};
	logic clk, rst_n, psel, penable, pwrite, er, pready, pslverr, ev_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] ev_idx, n;
	logic [3:0] ev_kind, k;
	logic [63:0] cfg;
	logic [8:0] cv, c;
	logic [6:0] id, d;
	logic [15:0] rate;
	logic [15:0] code [64];
	int err_count, checked, seed, i, j;
	fieldbus_node_status_monitor #(.STACK_VERSION(SV), .NODES(64)) dut (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.node_configured(cfg), .node_event_valid(ev_valid), .node_event_index(ev_idx),
		.node_event_kind(ev_kind), .master_enable(cv[8]), .internal_mem_error(cv[7]),
		.can_bus_off(cv[6]), .tx_buffer_full(cv[5]), .rx_buffer_full(cv[4]),
		.own_setting_error(cv[3]), .cfg_receive_error(cv[2]), .cfg_downloading(cv[1]),
		.own_node_id(id), .bus_rate_kbps(rate));
	node_event_model u_ev (.clk(clk), .valid(ev_valid), .index(ev_idx), .kind(ev_kind));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ---------------------------------------------------------------
	// Expectations and bus tasks
	// ---------------------------------------------------------------
	function automatic logic [15:0] exp_ms(logic [8:0] x, logic [6:0] a);
		if (!x[8]) return 16'h0000;
		if (x[7]) return 16'h00f8;
		if (x[6]) return 16'h00f4;
		if (x[5]) return 16'h00fb;
		if (x[4]) return 16'h00fc;
		if (x[3] || a == 7'h00) return 16'h00f5;
		if (x[2]) return 16'h00f3;
		if (x[1]) return 16'h00f2;
		return x[0] ? 16'h0000 : 16'h00f1;
	endfunction
	function automatic logic [31:0] exp_map(int r);
		logic [31:0] m;
		m = 32'h0;
		for (int b = 0; b < 16; b++) m[b] = cfg[r*16+b] && code[r*16+b] != 16'h0;
		return m;
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= $random(seed);
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(a, 1'b0);
		chk(rd, e);
		chk({31'h0, er}, 32'h0);
	endtask
	task automatic wrap_up();
		if (err_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		wrap_up();
	end
	initial begin
		seed = 12;
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{cv, cfg, rate} = '0;
		id = 7'h55;
		foreach (code[i]) code[i] = 16'h0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rate <= 16'($random(seed));
		rchk(12'h000, {16'h0, SV});
		rchk(12'h008, 32'h0);
		rchk(12'h004, {16'h0, rate});
		for (i = 0; i < 4; i++) rchk(12'h00c + 12'(i * 4), 32'h0);
		cfg <= {10'h3ff, 22'($random(seed)), 32'($random(seed))};
		for (j = 0; j < 52; j++) begin
			n = j < 22 ? 6'(63 - j % 12) : 6'($random(seed));
			k = j < 12 ? 4'(j) : (j < 22 ? 4'h0 : 4'($random(seed)));
			u_ev.report(n, k, j % 3);
			if (k < 4'ha && cfg[n]) code[n] = k == 4'h0 ? 16'h0 : 16'h00df + 16'(k);
			rchk(12'h100 + 12'(n) * 12'h004, cfg[n] ? {16'h0, code[n]} : 32'h0);
			rchk(12'h00c + 12'(n / 16) * 12'h004, exp_map(n / 16));
		end
		foreach (BAD[i]) begin
			apb(BAD[i], i == 0);
			chk(rd, 32'h0);
			chk({31'h0, er}, 32'h1);
		end
		for (j = 0; j < 40; j++) begin
			c = j < 8 ? 9'h101 | (9'h080 >> j) : (j == 8 ? 9'h100 : (j == 9 ? 9'h000
				: (j == 10 ? 9'h101 : 9'($random(seed)))));
			d = j == 10 ? 7'h00 : 7'h55;
			cv <= c;
			id <= d;
			cfg <= c[0] ? {32'($random(seed)), 32'($random(seed)) | 32'h1} : 64'h0;
			rate <= 16'($random(seed));
			repeat (3) @(posedge clk);
			rchk(12'h008, {16'h0, exp_ms(c, d)});
			rchk(12'h004, {16'h0, rate});
		end
		wrap_up();
	end
endmodule
